// *** logic/rvm_pkg.sv ***
package rvm_pkg;

    // vector numbers and counts
    localparam int unsigned NUM_VECTORS   = 38;
    localparam int unsigned NUM_SOURCES   = 37;           // vectors 2..38
    localparam int unsigned ADDR_W        = 20;           // word address width

    // program word addresses
    localparam logic [19:0] RESET_ADDR    = 20'h00000;
    localparam logic [19:0] VEC_STRIDE    = 20'h00002;
    localparam logic [19:0] VEC_FIRST     = 20'h00002;
    localparam logic [19:0] BOOT_ADDR_DEF = 20'hf0000;    // plain default, parameter overrides

    // reserved vector numbers as a mask over vectors 2..38 (bit i = vector i+2)
    localparam logic [36:0] RESERVED_MASK = 37'h06_1180_0700;

    // fuse encoding
    localparam logic        FUSE_PROGRAMMED = 1'b0;

    // reset values
    localparam logic [19:0] ADDR_RST      = 20'h00000;
    localparam logic [5:0]  VNUM_RST      = 6'h00;

    typedef struct packed {
        logic        valid;
        logic [5:0]  vec_num;
        logic [19:0] addr;
    } rvm_vector_s;

    typedef enum logic [1:0] {
        RVM_RUN   = 2'b01,
        RVM_RESET = 2'b10
    } rvm_state_e;

endpackage : rvm_pkg

// *** logic/rvm_vector_mapper.sv ***
`timescale 1ns/1ps
module rvm_vector_mapper #(
    parameter logic [19:0] BOOT_RESET_ADDR = rvm_pkg::BOOT_ADDR_DEF
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    input  wire logic                 boot_reset_fuse,
    input  wire logic                 vector_table_select,
    input  wire logic [36:0]          irq_pending,
    input  wire logic [36:0]          irq_enable,
    input  wire logic                 global_irq_enable,
    input  wire logic                 vector_taken,
    output rvm_pkg::rvm_vector_s      vector_out,
    output logic                      reset_entry,
    output logic [19:0]               reset_vector
);
    // irq_pending bit i is vector i+2:
    // 0..3 ext_request_0..3, 4..6 pin_change_req_0..2, 7 watchdog_timeout_irq,
    // 11..14 counter1, 15..17 counter0, 18 spi_done, 19..21 serial,
    // 22 supply_monitor, 25 two_wire, 26 flash_store_ready, 27 keyboard,
    // 29 fast_spi, 30/31 usb, 32 smart_card, 35 card_presence, 36 pin_change_req_3

    function automatic logic [19:0] vec_addr(input logic [5:0] n, input logic sel);
        logic [19:0] base;
        base = {13'h0000, n - 6'h01, 1'b0};
        vec_addr = sel ? base + BOOT_RESET_ADDR : base;
    endfunction : vec_addr

    // the fuse is a static strap but still arrives from outside the clock domain
    logic        fuse_s1_q;
    logic        fuse_s2_q;
    logic        sel_s1_q;
    logic        sel_s2_q;
    rvm_pkg::rvm_state_e state_q;
    rvm_pkg::rvm_state_e state_d;

    always_ff @(posedge core_clk) begin
        fuse_s1_q <= boot_reset_fuse;
        fuse_s2_q <= fuse_s1_q;
        sel_s1_q  <= vector_table_select;
        sel_s2_q  <= sel_s1_q;
    end

    // sources armed by their own enable and the global one
    wire logic [36:0] armed = irq_pending & irq_enable & {37{global_irq_enable}};

    // one slice per source group; reserved slots are tied off below, not masked
    wire logic [3:0]  ext_live      = armed[3:0];
    wire logic [3:0]  pin_chg_live  = {armed[36], armed[6:4]};
    wire logic        wdog_live     = armed[7];
    wire logic [3:0]  cnt1_live     = armed[14:11];
    wire logic [2:0]  cnt0_live     = armed[17:15];
    wire logic [3:0]  serial_live   = armed[21:18];
    wire logic [2:0]  sys_live      = {armed[26:25], armed[22]};
    wire logic [1:0]  fast_live     = {armed[29], armed[27]};
    wire logic [3:0]  usb_card_live = {armed[35], armed[32:30]};

    // a stray request on a reserved slot has no wire into the encoder at all
    wire logic [36:0] live = {pin_chg_live[3], usb_card_live[3], 2'h0, usb_card_live[2:0],
                              fast_live[1], 1'h0, fast_live[0], sys_live[2:1], 2'h0, sys_live[0],
                              serial_live, cnt0_live, cnt1_live, 3'h0, wdog_live,
                              pin_chg_live[2:0], ext_live};

    // priority encode: lowest vector number first
    logic [5:0] win_num;
    logic       win_any;
    always_comb begin
        win_num = 6'h00;
        win_any = 1'b0;
        for (int i = 36; i >= 0; i--) begin
            if (live[i]) begin
                win_num = 6'(i + 2);
                win_any = 1'b1;
            end
        end
    end

    wire logic [19:0] rst_target = (fuse_s2_q == rvm_pkg::FUSE_PROGRAMMED) ? BOOT_RESET_ADDR
                                                                          : rvm_pkg::RESET_ADDR;

    always_comb begin
        state_d = rvm_pkg::RVM_RUN;
        unique case (state_q)
            rvm_pkg::RVM_RESET: state_d = rvm_pkg::RVM_RUN;
            rvm_pkg::RVM_RUN:   state_d = rvm_pkg::RVM_RUN;
            default:            state_d = rvm_pkg::RVM_RUN;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q      <= rvm_pkg::RVM_RESET;
            vector_out   <= '0;
            reset_vector <= rvm_pkg::ADDR_RST;
        end else begin
            state_q      <= state_d;
            reset_vector <= rst_target;
            if (vector_taken && vector_out.valid) begin
                vector_out.valid <= 1'b0;
            end else begin
                vector_out.valid   <= win_any;
                vector_out.vec_num <= win_any ? win_num : rvm_pkg::VNUM_RST;
                vector_out.addr    <= win_any ? vec_addr(win_num, sel_s2_q) : rvm_pkg::ADDR_RST;
            end
        end
    end

    // one-cycle marker after reset release: reset_vector still holds ADDR_RST here and takes the fetch start address on the next edge
    assign reset_entry = (state_q == rvm_pkg::RVM_RESET) && !reset;

    property p_vec_spacing;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && !sel_s2_q && $stable(sel_s2_q)
            |-> vector_out.addr == {13'h0000, vector_out.vec_num - 6'h01, 1'b0};
    endproperty
    a_vec_spacing: assert property (p_vec_spacing) else $error("vector address not 2*(n-1)");

    property p_boot_offset;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && $past(sel_s2_q)
            |-> vector_out.addr == BOOT_RESET_ADDR + {13'h0000, vector_out.vec_num - 6'h01, 1'b0};
    endproperty
    a_boot_offset: assert property (p_boot_offset) else $error("boot offset missing");

    property p_no_reserved;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid |-> !rvm_pkg::RESERVED_MASK[vector_out.vec_num - 6'h02];
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved vector served");

    property p_enabled_only;
        @(posedge core_clk) disable iff (reset)
        !$past(global_irq_enable) |-> !vector_out.valid;
    endproperty
    a_enabled_only: assert property (p_enabled_only) else $error("vector raised while disabled");

    property p_lowest;
        @(posedge core_clk) disable iff (reset)
        $past(win_any) && !$past(vector_out.valid) |-> vector_out.vec_num == $past(win_num);
    endproperty
    a_lowest: assert property (p_lowest) else $error("winner not lowest");

    property p_reset_addr;
        @(posedge core_clk) disable iff (reset)
        $stable(fuse_s2_q) && fuse_s2_q |=> reset_vector == 20'h00000;
    endproperty
    a_reset_addr: assert property (p_reset_addr) else $error("reset not at zero");

    property p_boot_reset;
        @(posedge core_clk) disable iff (reset)
        $stable(fuse_s2_q) && !fuse_s2_q |=> reset_vector == BOOT_RESET_ADDR;
    endproperty
    a_boot_reset: assert property (p_boot_reset) else $error("boot reset address missed");

    property p_ext0;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && vector_out.vec_num == 6'h02 && !$past(sel_s2_q) |-> vector_out.addr == 20'h00002;
    endproperty
    a_ext0: assert property (p_ext0) else $error("ext request 0 not at 0x0002");

    property p_pc3;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && vector_out.vec_num == 6'h26 && !$past(sel_s2_q) |-> vector_out.addr == 20'h0004a;
    endproperty
    a_pc3: assert property (p_pc3) else $error("pin change 3 not at 0x004A");

    // table spot checks with the table in application space, the last one with it relocated
    property p_pc0;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && vector_out.vec_num == 6'h06 && !$past(sel_s2_q) |-> vector_out.addr == 20'h0000a;
    endproperty
    a_pc0: assert property (p_pc0) else $error("pin change 0 not at 0x000A");

    property p_wdog;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && vector_out.vec_num == 6'h09 && !$past(sel_s2_q) |-> vector_out.addr == 20'h00010;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog not at 0x0010");

    property p_cnt1_capt;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && vector_out.vec_num == 6'h0d && !$past(sel_s2_q) |-> vector_out.addr == 20'h00018;
    endproperty
    a_cnt1_capt: assert property (p_cnt1_capt) else $error("counter1 capture not at 0x0018");

    property p_cnt1_ovf;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && vector_out.vec_num == 6'h10 && !$past(sel_s2_q) |-> vector_out.addr == 20'h0001e;
    endproperty
    a_cnt1_ovf: assert property (p_cnt1_ovf) else $error("counter1 overflow not at 0x001E");

    property p_cnt0_ovf;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && vector_out.vec_num == 6'h13 && !$past(sel_s2_q) |-> vector_out.addr == 20'h00024;
    endproperty
    a_cnt0_ovf: assert property (p_cnt0_ovf) else $error("counter0 overflow not at 0x0024");

    property p_spi;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && vector_out.vec_num == 6'h14 && !$past(sel_s2_q) |-> vector_out.addr == 20'h00026;
    endproperty
    a_spi: assert property (p_spi) else $error("spi done not at 0x0026");

    property p_ser_tx;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && vector_out.vec_num == 6'h17 && !$past(sel_s2_q) |-> vector_out.addr == 20'h0002c;
    endproperty
    a_ser_tx: assert property (p_ser_tx) else $error("serial tx complete not at 0x002C");

    property p_store;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && vector_out.vec_num == 6'h1c && !$past(sel_s2_q) |-> vector_out.addr == 20'h00036;
    endproperty
    a_store: assert property (p_store) else $error("store ready not at 0x0036");

    property p_fast_spi;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && vector_out.vec_num == 6'h1f && !$past(sel_s2_q) |-> vector_out.addr == 20'h0003c;
    endproperty
    a_fast_spi: assert property (p_fast_spi) else $error("fast spi not at 0x003C");

    property p_usb_ep;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && vector_out.vec_num == 6'h20 && !$past(sel_s2_q) |-> vector_out.addr == 20'h0003e;
    endproperty
    a_usb_ep: assert property (p_usb_ep) else $error("usb endpoint not at 0x003E");

    property p_presence;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && vector_out.vec_num == 6'h25 && !$past(sel_s2_q) |-> vector_out.addr == 20'h00048;
    endproperty
    a_presence: assert property (p_presence) else $error("card presence not at 0x0048");

    property p_boot_start;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid && vector_out.vec_num == 6'h02 && $past(sel_s2_q)
            |-> vector_out.addr == BOOT_RESET_ADDR + 20'h00002;
    endproperty
    a_boot_start: assert property (p_boot_start) else $error("relocated table start wrong");

    // reset release, two steps: held, then let go
    sequence s_release;
        reset ##1 !reset;
    endsequence

    sequence s_running;
        !reset ##1 !reset;
    endsequence

    property p_entry_pulse;
        @(posedge core_clk) s_release |-> reset_entry;
    endproperty
    a_entry_pulse: assert property (p_entry_pulse) else $error("no entry marker after reset release");

    property p_entry_once;
        @(posedge core_clk) s_running |-> !reset_entry;
    endproperty
    a_entry_once: assert property (p_entry_once) else $error("entry marker outside first cycle");

    property p_reset_clear;
        @(posedge core_clk) reset |=> !vector_out.valid && reset_vector == rvm_pkg::ADDR_RST;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left a vector or start address");

    // the fetch side takes a vector, then the offer drops for one cycle
    sequence s_take;
        vector_out.valid && vector_taken;
    endsequence

    sequence s_still_pending;
        |(irq_pending & irq_enable & ~rvm_pkg::RESERVED_MASK) && global_irq_enable;
    endsequence

    property p_drop;
        @(posedge core_clk) disable iff (reset)
        s_take |=> !vector_out.valid;
    endproperty
    a_drop: assert property (p_drop) else $error("vector not dropped after take");

    property p_reoffer;
        @(posedge core_clk) disable iff (reset)
        s_take ##1 s_still_pending |=> vector_out.valid;
    endproperty
    a_reoffer: assert property (p_reoffer) else $error("pending request not offered again");

    // the winner was armed, and nothing armed sat below it
    property p_winner_armed;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid |-> $past(global_irq_enable)
            && ((($past(irq_pending & irq_enable)) >> (vector_out.vec_num - 6'h02)) & 37'h1) == 37'h1;
    endproperty
    a_winner_armed: assert property (p_winner_armed) else $error("vector served for an unarmed source");

    property p_none_lower;
        @(posedge core_clk) disable iff (reset)
        vector_out.valid |-> ($past(irq_pending & irq_enable & ~rvm_pkg::RESERVED_MASK)
            & ((37'h1 << (vector_out.vec_num - 6'h02)) - 37'h1)) == 37'h0;
    endproperty
    a_none_lower: assert property (p_none_lower) else $error("a lower vector was pending");

    property p_answer;
        @(posedge core_clk) disable iff (reset)
        !(vector_out.valid && vector_taken) |=> vector_out.valid
            == $past(|(irq_pending & irq_enable & ~rvm_pkg::RESERVED_MASK) && global_irq_enable);
    endproperty
    a_answer: assert property (p_answer) else $error("offer does not follow armed requests");

endmodule : rvm_vector_mapper

// *** verification/rvm_core_model.sv ***
`timescale 1ns/1ps
module rvm_core_model (
    input  wire logic            core_clk,
    input  wire logic            reset,
    input  rvm_pkg::rvm_vector_s vector_out,
    output logic                 vector_taken
);
    // takes each vector one cycle late, a fetch that stalls
    always_ff @(posedge core_clk) begin
        if (reset)
            vector_taken <= 1'b0;
        else
            vector_taken <= vector_out.valid & ~vector_taken;
    end
endmodule : rvm_core_model

// *** verification/rvm_vector_mapper_bench.sv ***
`timescale 1ns/1ps
module rvm_vector_mapper_bench;
    localparam logic [19:0] BA = 20'hf0000;
    // vectors 10..12, 25, 26, 30, 35, 36
    localparam logic [36:0] RSV = 37'h0611800700;
    logic                 core_clk = 1'b0;
    logic                 reset    = 1'b1;
    logic                 fuse     = 1'b1;
    logic                 sel      = 1'b0;
    logic [36:0]          pend     = 37'h0;
    logic [36:0]          en       = '1;
    logic                 gie      = 1'b1;
    logic                 taken;
    logic                 rst_entry;
    logic [19:0]          rst_vec;
    rvm_pkg::rvm_vector_s vo;
    int                   fail_count = 0;
    int                   cmp_count  = 0;
    always #2.5 core_clk = ~core_clk;
    rvm_vector_mapper #(.BOOT_RESET_ADDR(BA)) rvm_vector_mapper_i (
        .core_clk(core_clk), .reset(reset), .boot_reset_fuse(fuse), .vector_table_select(sel),
        .irq_pending(pend), .irq_enable(en), .global_irq_enable(gie), .vector_taken(taken),
        .vector_out(vo), .reset_entry(rst_entry), .reset_vector(rst_vec));
    rvm_core_model rvm_core_model_i (.core_clk(core_clk), .reset(reset), .vector_out(vo), .vector_taken(taken));
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit
    task automatic boot_case(input logic f, input logic [19:0] exp);
        @(posedge core_clk);
        fuse  <= f;
        reset <= 1'b1;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        chk_bit("reset_entry", 1'b1, rst_entry);
        @(posedge core_clk);
        #1;
        chk_bit("reset_entry", 1'b0, rst_entry);
        repeat (5) @(posedge core_clk);
        #1;
        chk("reset_vector", exp, rst_vec);
    endtask : boot_case
    // one request set in, the vector handed to the core judged, then drained
    task automatic offer(input logic [36:0] p, input logic v, input logic [5:0] n, input logic [19:0] a);
        @(posedge core_clk);
        pend <= p;
        repeat (6) begin
            @(posedge core_clk);
            #1;
            if (vo.valid === 1'b1)
                break;
        end
        chk_bit("valid", v, vo.valid);
        if (v) begin
            chk("vec_num", 20'(n), 20'(vo.vec_num));
            chk("addr", a, vo.addr);
        end
        @(posedge core_clk);
        pend <= 37'h0;
        repeat (4) @(posedge core_clk);
    endtask : offer
    task automatic sweep(input logic s);
        @(posedge core_clk);
        sel <= s;
        // select crosses a two-flop sync
        repeat (4) @(posedge core_clk);
        for (int i = 0; i < 37; i++)
            offer(37'h1 << i, ~RSV[i], 6'(i + 2), (s ? BA : 20'h0) + 20'(2 * (i + 1)));
    endtask : sweep
    task automatic gating();
        @(posedge core_clk);
        en <= ~37'h1;
        offer(37'h1, 1'b0, 6'h0, 20'h0);
        en  <= '1;
        gie <= 1'b0;
        offer(37'h2, 1'b0, 6'h0, 20'h0);
        gie <= 1'b1;
    endtask : gating
    // a held request is offered, taken, dropped one cycle, then offered again
    task automatic retake();
        @(posedge core_clk);
        pend <= 37'h80;
        @(posedge core_clk);
        #1;
        chk_bit("offer", 1'b1, vo.valid);
        @(posedge core_clk);
        #1;
        chk_bit("offer_held", 1'b1, vo.valid);
        @(posedge core_clk);
        #1;
        chk_bit("offer_dropped", 1'b0, vo.valid);
        @(posedge core_clk);
        #1;
        chk_bit("offer_again", 1'b1, vo.valid);
        chk("addr_again", BA + 20'h00010, vo.addr);
        @(posedge core_clk);
        pend <= 37'h0;
        repeat (4) @(posedge core_clk);
    endtask : retake
    initial begin
        boot_case(1'b0, BA);
        boot_case(1'b1, 20'h00000);
        sweep(1'b0);
        sweep(1'b1);
        offer(37'h28, 1'b1, 6'h05, BA + 20'h8);
        offer(37'h1700, 1'b1, 6'h0e, BA + 20'h1a);
        gating();
        retake();
        test_done();
    end
    initial begin
        #100000;
        fail_count++;
        test_done();
    end
endmodule : rvm_vector_mapper_bench
